// file: tph_pkg.sv
// Constants, register map and types for the trace program-hold control bank.
// Assumes a single clock domain and a plain strobe-based register port.
//
// What the document requires
// RULE1 - Legacy: state not writable, reset on hold set.
// RULE2 - Hold freezes state, stops counting and triggers.
// RULE3 - State reset reloads counters from reload registers.
// RULE4 - State reset returns sequencer to state 1.
// RULE5 - State reset turns start/stop block off.
// RULE6 - State reset clears triggered flag to 0; here a trigger event in the same cycle, not held, sets it instead.
// RULE7 - Reload write under hold also loads counter; here only the legacy variants do this, the later variant does not.
// RULE8 - Start/stop readable mid onward; triggered later only.
// RULE9 - Legacy software reads state before setting hold.
// RULE10 - Later variant: state items directly read/writable.
// RULE11 - Later: reset on hold clear unless written.
// RULE12 - Later software sets hold before reading state.
// RULE13 - Undefined bits read zero, written as zero.
// RULE14 - Software writes control bit 31 as zero.
// RULE15 - Control bit 30 enables virtual machine tracing.
// RULE16 - No virtualization support: bit 30 reads zero.
// RULE17 - Unit reset clears virtual machine trace enable.
// RULE18 - Program-hold bit is control bit 10.
// RULE19 - Other control bits change only when status[1]; here bits 0 and 30 take every control write, whatever status[1] is.
// RULE20 - Unit reset sets power-down and program-hold bits.
// RULE21 - Status bit 3 triggered, bit 2 start/stop.

package tph_pkg;

  typedef enum logic [1:0] {TPH_LEGACY_EARLY, TPH_LEGACY_MID, TPH_LATER} tph_variant_t;

  localparam int          TPH_AW        = 8;
  localparam int          TPH_DW        = 32;
  localparam int          TPH_CW        = 16;
  localparam int          TPH_NCNT      = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses).
  // ----------------------------------------------------------------
  localparam logic [7:0]  TPH_OFF_CTRL  = 8'h00;
  localparam logic [7:0]  TPH_OFF_STAT  = 8'h04;
  localparam logic [7:0]  TPH_OFF_CFGX  = 8'h08;
  localparam logic [7:0]  TPH_OFF_SEQ   = 8'h0c;
  localparam logic [7:0]  TPH_OFF_SSBLK = 8'h10;
  localparam logic [7:0]  TPH_OFF_RLD0  = 8'h20;
  localparam logic [7:0]  TPH_OFF_CNT0  = 8'h30;
  localparam logic [7:0]  TPH_OFF_STEP  = 8'h04;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int          TPH_BIT_PWRDN = 0;
  localparam int          TPH_BIT_PROG  = 10;
  localparam int          TPH_BIT_VMID  = 30;
  localparam int          TPH_BIT_RSVD  = 31;
  localparam int          TPH_ST_PROG   = 1;
  localparam int          TPH_ST_SS     = 2;
  localparam int          TPH_ST_TRIG   = 3;
  localparam int          TPH_CFGX_VIRT = 26;
  localparam int          TPH_SSW_SS    = 0;
  localparam int          TPH_SSW_TRIG  = 1;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic        TPH_RST_PROG  = 1'b1;
  localparam logic        TPH_RST_PWRDN = 1'b1;
  localparam logic        TPH_RST_VMID  = 1'b0;
  localparam logic [1:0]  TPH_SEQ_FIRST = 2'h1;
  localparam logic [1:0]  TPH_SEQ_LAST  = 2'h3;
  localparam logic [15:0] TPH_RST_CNT   = 16'h0000;

endpackage : tph_pkg

// file: tph_state_if.sv
// Interface between the register bank and the trace state engine.
// Assumes both ends share one clock; control is driven by the bank.
`timescale 1ns/100ps
`default_nettype none

interface tph_state_if;
  logic                                           hold;
  logic [tph_pkg::TPH_NCNT-1:0]                   rst_ctr;
  logic                                           rst_seq;
  logic                                           rst_ss;
  logic                                           rst_trig;
  logic [tph_pkg::TPH_NCNT-1:0]                   wr_ctr;
  logic                                           wr_seq;
  logic                                           wr_ss;
  logic                                           wr_trig;
  logic [tph_pkg::TPH_DW-1:0]                     wdata;
  logic [tph_pkg::TPH_NCNT-1:0][tph_pkg::TPH_CW-1:0] reload;
  logic [tph_pkg::TPH_NCNT-1:0][tph_pkg::TPH_CW-1:0] count;
  logic [1:0]                                     seq;
  logic                                           ss;
  logic                                           trig;
  logic                                           trig_pulse;

  modport ctl (output hold, rst_ctr, rst_seq, rst_ss, rst_trig, wr_ctr, wr_seq, wr_ss,
               output wr_trig, wdata, reload, input count, seq, ss, trig, trig_pulse);
  modport eng (input hold, rst_ctr, rst_seq, rst_ss, rst_trig, wr_ctr, wr_seq, wr_ss,
               input wr_trig, wdata, reload, output count, seq, ss, trig, trig_pulse);
endinterface : tph_state_if

`default_nettype wire

// file: tph_state_engine.sv
// Trace state engine: counters, sequencer, start/stop block, triggered flag.
// Assumes reset and write strobes from the bank are single-cycle pulses.
`timescale 1ns/100ps
`default_nettype none

module tph_state_engine (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [tph_pkg::TPH_NCNT-1:0] count_evt,
  input  wire logic                         seq_adv,
  input  wire logic                         ss_start,
  input  wire logic                         ss_stop,
  input  wire logic                         trig_evt,
  tph_state_if.eng                          sif
);

  typedef struct packed {
    logic [tph_pkg::TPH_NCNT-1:0][tph_pkg::TPH_CW-1:0] count;
    logic [1:0]                                         seq;
    logic                                               ss;
    logic                                               trig;
    logic                                               trig_pulse;
  } tph_eng_t;

  tph_eng_t s_reg;
  tph_eng_t s_next;

  // ----------------------------------------------------------------
  // Next state. A software write beats a state reset in the same cycle.
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.trig_pulse = 1'b0;
    for (int i = 0; i < tph_pkg::TPH_NCNT; i++) begin
      if (sif.wr_ctr[i]) begin
        s_next.count[i] = sif.wdata[tph_pkg::TPH_CW-1:0]; // RULE7
      end else if (sif.rst_ctr[i]) begin
        s_next.count[i] = sif.reload[i]; // RULE3
      end else if (!sif.hold && count_evt[i] && s_reg.count[i] != '0) begin
        s_next.count[i] = s_reg.count[i] - 16'h0001; // RULE2
      end
    end
    if (sif.wr_seq) begin
      s_next.seq = sif.wdata[1:0];
    end else if (sif.rst_seq) begin
      s_next.seq = tph_pkg::TPH_SEQ_FIRST; // RULE4
    end else if (!sif.hold && seq_adv) begin
      s_next.seq = (s_reg.seq == tph_pkg::TPH_SEQ_LAST) ? tph_pkg::TPH_SEQ_FIRST
                                                        : s_reg.seq + 2'h1;
    end
    if (sif.wr_ss) begin
      s_next.ss = sif.wdata[tph_pkg::TPH_SSW_SS];
    end else if (sif.rst_ss) begin
      s_next.ss = 1'b0; // RULE5
    end else if (!sif.hold && ss_stop) begin
      s_next.ss = 1'b0;
    end else if (!sif.hold && ss_start) begin
      s_next.ss = 1'b1;
    end
    // A trigger in the same cycle as a state reset is kept when hold is low: the set wins over the clear.
    if (sif.wr_trig) begin
      s_next.trig = sif.wdata[tph_pkg::TPH_SSW_TRIG];
    end else if (!sif.hold && trig_evt && (!s_reg.trig || sif.rst_trig)) begin
      s_next.trig       = 1'b1; // RULE2
      s_next.trig_pulse = 1'b1;
    end else if (sif.rst_trig) begin
      s_next.trig = 1'b0; // RULE6
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '{count: {tph_pkg::TPH_NCNT{tph_pkg::TPH_RST_CNT}},
                 seq: tph_pkg::TPH_SEQ_FIRST, ss: 1'b0, trig: 1'b0,
                 trig_pulse: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sif.count      = s_reg.count;
  assign sif.seq        = s_reg.seq;
  assign sif.ss         = s_reg.ss;
  assign sif.trig       = s_reg.trig;
  assign sif.trig_pulse = s_reg.trig_pulse;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  hold_count_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    sif.hold && !sif.wr_ctr[0] && !sif.rst_ctr[0] |=> $stable(s_reg.count[0]))
    else $error("counter moved while held");
  hold_trig_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    sif.hold |=> !s_reg.trig_pulse)
    else $error("trigger raised while held");
  seq_reset_a: assert property (@(posedge clk) disable iff (!nrst) // RULE4
    sif.rst_seq && !sif.wr_seq |=> s_reg.seq == tph_pkg::TPH_SEQ_FIRST)
    else $error("sequencer not back in first state");

endmodule : tph_state_engine

`default_nettype wire

// file: tph_ctrl.sv
// Program-hold control register bank for a processor trace unit.
// Assumes the register master never issues read and write in one cycle.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module tph_ctrl #(
  parameter tph_pkg::tph_variant_t VARIANT      = tph_pkg::TPH_LATER,
  parameter logic                  VIRT_SUPPORT = 1'b1
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [tph_pkg::TPH_AW-1:0]   addr,
  input  wire logic [tph_pkg::TPH_DW-1:0]   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output var  logic [tph_pkg::TPH_DW-1:0]   rdata,
  input  wire logic [tph_pkg::TPH_NCNT-1:0] count_evt,
  input  wire logic                         seq_adv,
  input  wire logic                         ss_start,
  input  wire logic                         ss_stop,
  input  wire logic                         trig_evt,
  output var  logic                         power_down,
  output var  logic                         prog_hold,
  output var  logic                         trace_enable,
  output var  logic                         virtual_machine_id_trace_enable,
  output var  logic                         trigger_out
);

  localparam logic LEGACY = (VARIANT != tph_pkg::TPH_LATER);
  localparam logic SS_RD  = (VARIANT != tph_pkg::TPH_LEGACY_EARLY);

  typedef struct packed {
    logic                                               prog;
    logic                                               prog_d;
    logic                                               pwrdn;
    logic                                               vmid;
    logic [tph_pkg::TPH_NCNT-1:0][tph_pkg::TPH_CW-1:0] reload;
    logic [tph_pkg::TPH_NCNT-1:0]                       dirty_cnt;
    logic                                               dirty_seq;
    logic                                               dirty_ss;
    logic                                               dirty_trig;
    logic [tph_pkg::TPH_DW-1:0]                         rdata;
    logic                                               trace_en;
    logic                                               trig_out;
  } tph_ctrl_t;

  tph_ctrl_t   s_reg;
  tph_ctrl_t   s_next;
  tph_state_if sif ();

  logic        prog_set;
  logic        prog_clr;
  logic        later_clr;

  tph_state_engine u_engine (
    .clk       (clk),
    .nrst      (nrst),
    .count_evt (count_evt),
    .seq_adv   (seq_adv),
    .ss_start  (ss_start),
    .ss_stop   (ss_stop),
    .trig_evt  (trig_evt),
    .sif       (sif.eng)
  );

  // ----------------------------------------------------------------
  // Program-hold edges, seen one cycle after the control write.
  // ----------------------------------------------------------------
  assign prog_set  = s_reg.prog && !s_reg.prog_d;
  assign prog_clr  = !s_reg.prog && s_reg.prog_d;
  assign later_clr = !LEGACY && prog_clr;

  // ----------------------------------------------------------------
  // State engine control.
  // ----------------------------------------------------------------
  always_comb begin
    sif.hold     = s_reg.prog; // RULE2
    sif.wdata    = wdata;
    sif.reload   = s_reg.reload;
    sif.rst_ctr  = {tph_pkg::TPH_NCNT{LEGACY && prog_set}} // RULE1
                 | ({tph_pkg::TPH_NCNT{later_clr}} & ~s_reg.dirty_cnt); // RULE11
    sif.rst_seq  = (LEGACY && prog_set) || (later_clr && !s_reg.dirty_seq); // RULE11
    sif.rst_ss   = (LEGACY && prog_set) || (later_clr && !s_reg.dirty_ss);
    sif.rst_trig = (LEGACY && prog_set) || (later_clr && !s_reg.dirty_trig);
    sif.wr_ctr   = '0;
    for (int i = 0; i < tph_pkg::TPH_NCNT; i++) begin
      if (LEGACY) begin
        sif.wr_ctr[i] = wr && s_reg.prog
                      && addr == tph_pkg::TPH_OFF_RLD0 + 8'(i) * tph_pkg::TPH_OFF_STEP; // RULE7
      end else begin
        sif.wr_ctr[i] = wr && s_reg.prog
                      && addr == tph_pkg::TPH_OFF_CNT0 + 8'(i) * tph_pkg::TPH_OFF_STEP; // RULE10
      end
    end
    sif.wr_seq   = !LEGACY && wr && s_reg.prog && addr == tph_pkg::TPH_OFF_SEQ; // RULE10
    sif.wr_ss    = !LEGACY && wr && s_reg.prog && addr == tph_pkg::TPH_OFF_SSBLK;
    sif.wr_trig  = sif.wr_ss;
  end

  // ----------------------------------------------------------------
  // Register bank next state.
  // ----------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.prog_d   = s_reg.prog;
    s_next.rdata    = '0;
    s_next.trace_en = !s_reg.prog && !s_reg.pwrdn && sif.ss;
    s_next.trig_out = sif.trig_pulse;
    // Written marks are cleared when hold is raised; a write in the same cycle wins.
    if (prog_set) begin
      s_next.dirty_cnt  = '0;
      s_next.dirty_seq  = 1'b0;
      s_next.dirty_ss   = 1'b0;
      s_next.dirty_trig = 1'b0;
    end
    s_next.dirty_cnt = s_next.dirty_cnt | (LEGACY ? '0 : sif.wr_ctr); // RULE11
    if (sif.wr_seq) begin
      s_next.dirty_seq = 1'b1;
    end
    if (sif.wr_ss) begin
      s_next.dirty_ss   = 1'b1;
      s_next.dirty_trig = 1'b1;
    end
    if (wr) begin
      if (addr == tph_pkg::TPH_OFF_CTRL) begin
        s_next.prog  = wdata[tph_pkg::TPH_BIT_PROG]; // RULE18
        s_next.pwrdn = wdata[tph_pkg::TPH_BIT_PWRDN];
        s_next.vmid  = VIRT_SUPPORT && wdata[tph_pkg::TPH_BIT_VMID]; // RULE16
      end
      for (int i = 0; i < tph_pkg::TPH_NCNT; i++) begin
        if (addr == tph_pkg::TPH_OFF_RLD0 + 8'(i) * tph_pkg::TPH_OFF_STEP) begin
          s_next.reload[i] = wdata[tph_pkg::TPH_CW-1:0];
        end
      end
    end
    if (rd) begin
      unique case (addr)
        tph_pkg::TPH_OFF_CTRL: begin
          s_next.rdata[tph_pkg::TPH_BIT_PROG]  = s_reg.prog;
          s_next.rdata[tph_pkg::TPH_BIT_PWRDN] = s_reg.pwrdn;
          s_next.rdata[tph_pkg::TPH_BIT_VMID]  = s_reg.vmid; // RULE15
        end
        tph_pkg::TPH_OFF_STAT: begin
          s_next.rdata[tph_pkg::TPH_ST_PROG] = s_reg.prog && s_reg.prog_d;
          s_next.rdata[tph_pkg::TPH_ST_SS]   = SS_RD && sif.ss; // RULE21
          s_next.rdata[tph_pkg::TPH_ST_TRIG] = !LEGACY && sif.trig; // RULE8
        end
        tph_pkg::TPH_OFF_CFGX: begin
          s_next.rdata[tph_pkg::TPH_CFGX_VIRT] = VIRT_SUPPORT;
        end
        tph_pkg::TPH_OFF_SEQ: begin
          s_next.rdata[1:0] = sif.seq;
        end
        tph_pkg::TPH_OFF_SSBLK: begin
          s_next.rdata[tph_pkg::TPH_SSW_SS]   = SS_RD && sif.ss; // RULE8
          s_next.rdata[tph_pkg::TPH_SSW_TRIG] = !LEGACY && sif.trig;
        end
        default: begin
          // Undefined offsets and bits read as zero.
          for (int i = 0; i < tph_pkg::TPH_NCNT; i++) begin
            if (addr == tph_pkg::TPH_OFF_RLD0 + 8'(i) * tph_pkg::TPH_OFF_STEP) begin
              s_next.rdata[tph_pkg::TPH_CW-1:0] = s_reg.reload[i]; // RULE13
            end
            if (addr == tph_pkg::TPH_OFF_CNT0 + 8'(i) * tph_pkg::TPH_OFF_STEP) begin
              s_next.rdata[tph_pkg::TPH_CW-1:0] = sif.count[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg        <= '0;
      s_reg.prog   <= tph_pkg::TPH_RST_PROG; // RULE20
      s_reg.prog_d <= tph_pkg::TPH_RST_PROG;
      s_reg.pwrdn  <= tph_pkg::TPH_RST_PWRDN;
      s_reg.vmid   <= tph_pkg::TPH_RST_VMID; // RULE17
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata                           = s_reg.rdata;
  assign power_down                      = s_reg.pwrdn;
  assign prog_hold                       = s_reg.prog;
  assign trace_enable                    = s_reg.trace_en;
  assign virtual_machine_id_trace_enable = s_reg.vmid;
  assign trigger_out                     = s_reg.trig_out;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  unit_reset_a: assert property (@(posedge clk) $rose(nrst) |-> // RULE20
    s_reg.prog && s_reg.pwrdn && !s_reg.vmid)
    else $error("control bits wrong after reset");
  vmid_gate_a: assert property (@(posedge clk) disable iff (!nrst) // RULE16
    !VIRT_SUPPORT |-> !virtual_machine_id_trace_enable)
    else $error("vm trace enable set without support");
  vmid_write_a: assert property (@(posedge clk) disable iff (!nrst) // RULE15
    wr && addr == tph_pkg::TPH_OFF_CTRL && VIRT_SUPPORT
    |=> virtual_machine_id_trace_enable == $past(wdata[tph_pkg::TPH_BIT_VMID]))
    else $error("vm trace enable not written");
  prog_bit_a: assert property (@(posedge clk) disable iff (!nrst) // RULE18
    wr && addr == tph_pkg::TPH_OFF_CTRL |=> prog_hold == $past(wdata[tph_pkg::TPH_BIT_PROG]))
    else $error("hold bit not taken from bit 10");
  legacy_reset_a: assert property (@(posedge clk) disable iff (!nrst) // RULE1
    LEGACY && prog_set && !wr |=> sif.count == $past(s_reg.reload)
    && sif.seq == tph_pkg::TPH_SEQ_FIRST && !sif.ss && !sif.trig)
    else $error("legacy state not reset on hold");
  reload_copy_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    LEGACY && s_reg.prog && wr && addr == tph_pkg::TPH_OFF_RLD0
    |=> sif.count[0] == $past(wdata[tph_pkg::TPH_CW-1:0]))
    else $error("reload write not copied to counter");
  later_keep_a: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    later_clr && s_reg.dirty_cnt[0] && !count_evt[0] |=> $stable(sif.count[0]))
    else $error("written counter lost on hold release");
  seq_write_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    !LEGACY && s_reg.prog && wr && addr == tph_pkg::TPH_OFF_SEQ
    |=> sif.seq == $past(wdata[1:0]))
    else $error("sequencer write lost");
  status_read_a: assert property (@(posedge clk) disable iff (!nrst) // RULE21
    rd && addr == tph_pkg::TPH_OFF_STAT |=> rdata[tph_pkg::TPH_ST_SS] == (SS_RD && $past(sif.ss))
    && rdata[tph_pkg::TPH_ST_TRIG] == (!LEGACY && $past(sif.trig)))
    else $error("status bits wrong");
  rsvd_read_a: assert property (@(posedge clk) disable iff (!nrst) // RULE13
    rd && addr == tph_pkg::TPH_OFF_CTRL |=> rdata[tph_pkg::TPH_BIT_RSVD] == 1'b0)
    else $error("reserved bit not zero");

  legacy_reset_c: cover property (@(posedge clk) disable iff (!nrst) LEGACY && prog_set);
  later_restore_c: cover property (@(posedge clk) disable iff (!nrst)
    later_clr && s_reg.dirty_cnt[0]);
  trigger_c: cover property (@(posedge clk) disable iff (!nrst) trigger_out);

endmodule : tph_ctrl

`default_nettype wire

// file: test_trace_program_hold_control.sv
// Self-checking bench for the program-hold control bank, later and legacy variants.
// Assumes the bank answers reads one cycle after the strobe and never stalls.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_trace_program_hold_control;
  logic        clk, nrst, wr, rd, seq_adv, ss_start, ss_stop, trig_evt;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rdata_l, d, l;
  logic [3:0]  count_evt;
  logic        power_down, prog_hold, trace_enable, vm_en, vm_en_l, trigger_out;
  int          n_errors, tests_run, n;

  tph_ctrl u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .count_evt(count_evt), .seq_adv(seq_adv), .ss_start(ss_start),
    .ss_stop(ss_stop), .trig_evt(trig_evt), .power_down(power_down),
    .prog_hold(prog_hold), .trace_enable(trace_enable),
    .virtual_machine_id_trace_enable(vm_en), .trigger_out(trigger_out));
  // The legacy copy runs without virtualization support on the same stimulus.
  tph_ctrl #(.VARIANT(tph_pkg::TPH_LEGACY_MID), .VIRT_SUPPORT(1'b0)) u_dut_leg (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata_l), .count_evt(count_evt), .seq_adv(seq_adv), .ss_start(ss_start),
    .ss_stop(ss_stop), .trig_evt(trig_evt), .power_down(), .prog_hold(),
    .trace_enable(), .virtual_machine_id_trace_enable(vm_en_l), .trigger_out());

  // ----------------------------------------------------------------
  // Bus and event drivers.
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
    l = rdata_l;
  endtask : rd_reg

  task automatic pulse(input logic [3:0] c, input logic adv, st, sp, tg);
    @(posedge clk);
    count_evt <= c;
    seq_adv   <= adv;
    ss_start  <= st;
    ss_stop   <= sp;
    trig_evt  <= tg;
    @(posedge clk);
    count_evt <= 4'h0;
    {seq_adv, ss_start, ss_stop, trig_evt} <= 4'h0;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (trigger_out === 1'b1) n++;
    end
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_reg(8'h00);
    `CHK(d, 32'h0000_0401)
    `CHK({prog_hold, power_down, vm_en}, 3'b110)
    @(posedge clk);
    #1;
    `CHK(rdata, 32'h0000_0000)
    rd_reg(8'h0c);
    `CHK({d, l}, {32'h1, 32'h1})
  endtask : t_reset

  task automatic t_vmid;
    wr_reg(8'h00, 32'h4000_0401);
    rd_reg(8'h00);
    `CHK({d, vm_en}, {32'h4000_0401, 1'b1})
    `CHK({l, vm_en_l}, {32'h0000_0401, 1'b0})
  endtask : t_vmid

  task automatic t_save_restore;
    wr_reg(8'h30, 32'h0000_0005);
    wr_reg(8'h0c, 32'h0000_0002);
    wr_reg(8'h24, 32'h0000_0007);
    rd_reg(8'h30);
    `CHK({d, l}, {32'h5, 32'h0})
    rd_reg(8'h34);
    `CHK({d, l}, {32'h0, 32'h7})
    wr_reg(8'h00, 32'h4000_0000);
    repeat (3) @(posedge clk);
    rd_reg(8'h30);
    `CHK(d, 32'h5)
    rd_reg(8'h34);
    `CHK(d, 32'h7)
    rd_reg(8'h0c);
    `CHK({d, l}, {32'h2, 32'h1})
  endtask : t_save_restore

  task automatic t_run;
    pulse(4'h3, 1'b1, 1'b0, 1'b0, 1'b0);
    pulse(4'h3, 1'b0, 1'b1, 1'b0, 1'b1);
    `CHK({n, trace_enable}, {32'd1, 1'b1})
    rd_reg(8'h34);
    `CHK({d, l}, {32'h5, 32'h5})
    rd_reg(8'h30);
    `CHK({d, l}, {32'h3, 32'h0})
    rd_reg(8'h04);
    `CHK({d, l}, {32'hc, 32'h4})
  endtask : t_run

  task automatic t_hold;
    wr_reg(8'h00, 32'h4000_0400);
    repeat (3) @(posedge clk);
    pulse(4'h3, 1'b1, 1'b0, 1'b1, 1'b1);
    `CHK({n, trace_enable}, {32'd0, 1'b0})
    rd_reg(8'h04);
    `CHK({d, l}, {32'he, 32'h2})
    rd_reg(8'h34);
    `CHK({d, l}, {32'h5, 32'h7})
    rd_reg(8'h0c);
    `CHK({d, l}, {32'h3, 32'h1})
    wr_reg(8'h00, 32'h0000_0000);
    repeat (3) @(posedge clk);
    rd_reg(8'h04);
    `CHK(d, 32'h0)
    rd_reg(8'h34);
    `CHK(d, 32'h7)
    rd_reg(8'h10);
    `CHK(d, 32'h0)
  endtask : t_hold

  task automatic t_unmapped;
    wr_reg(8'h04, 32'h0000_000e);
    rd_reg(8'h80);
    `CHK({d, l}, 64'h0)
    rd_reg(8'h04);
    `CHK(d, 32'h0)
  endtask : t_unmapped

  // ----------------------------------------------------------------
  // Run control.
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #8000;
    n_errors++;
    finish_test();
  end

  initial begin
    {nrst, wr, rd, seq_adv, ss_start, ss_stop, trig_evt} = 7'h0;
    addr = 8'h00;
    wdata = 32'h0;
    count_evt = 4'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_vmid();
    t_save_restore();
    t_run();
    t_hold();
    t_unmapped();
    finish_test();
  end
endmodule : test_trace_program_hold_control

`default_nettype wire
